/* src/acsr_clk_sel.sv */
// Conversion clock generator: system clock divider or synchronised RC clock
`timescale 1ns/1ns
module acsr_clk_sel (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  acsr_pkg::acsr_clk_code_type     clk_code,
  input  wire logic                       rc_clk_pin,
  output logic                            conv_clk,
  output logic                            rc_mode
);
  import acsr_pkg::*;

  logic [ACSR_DIV_W-1:0] cnt_q;
  logic [ACSR_DIV_W-1:0] cnt_d;
  logic [2:0]            sync_q;
  logic [2:0]            sync_d;
  logic                  rc_lvl_q;
  logic                  rc_lvl_d;
  logic                  conv_clk_q;
  logic                  conv_clk_d;
  logic                  rc_mode_q;
  logic                  rc_mode_d;

  always_comb begin
    cnt_d  = cnt_q + 6'h01;
    sync_d = {sync_q[1:0], rc_clk_pin};
    // Only a level seen by both later stages counts; stage 0 feeds stage 1 only
    rc_lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : rc_lvl_q;
    rc_mode_d = (clk_code[1:0] == ACSR_CS_RC_TAIL);
    conv_clk_d = rc_mode_d ? rc_lvl_d : cnt_d[acsr_div_bit(clk_code)];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q      <= '0;
      sync_q     <= 3'h0;
      rc_lvl_q   <= 1'b0;
      conv_clk_q <= 1'b0;
      rc_mode_q  <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      sync_q     <= sync_d;
      rc_lvl_q   <= rc_lvl_d;
      conv_clk_q <= conv_clk_d;
      rc_mode_q  <= rc_mode_d;
    end
  end

  assign conv_clk = conv_clk_q;
  assign rc_mode  = rc_mode_q;

  chk_div_two: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_code == 3'h0 && $past(clk_code) == 3'h0) |=> conv_clk != $past(conv_clk))
    else $error("divide by two clock does not toggle each cycle");

  chk_rc_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_code[1:0] == 2'h3) |=> rc_mode)
    else $error("code ending in 11 did not select the RC clock");

  chk_div_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_code[1:0] != 2'h3) |=> !rc_mode)
    else $error("divider code left the RC clock selected");

endmodule : acsr_clk_sel

/* src/acsr_pkg.sv */
// Constants and types for the converter clock select and result registers
package acsr_pkg;

  // Byte addresses on the register bus
  localparam logic [7:0] ACSR_OFS_CCC       = 8'h00;
  localparam logic [7:0] ACSR_OFS_RHI       = 8'h04;
  localparam logic [7:0] ACSR_OFS_RLO       = 8'h08;
  localparam logic [7:0] ACSR_OFS_FMT       = 8'h0c;

  localparam int         ACSR_CS_LSB        = 4;
  localparam int         ACSR_CS_MSB        = 6;
  localparam int         ACSR_FMT_BIT       = 0;
  localparam int         ACSR_RES_W         = 10;
  localparam int         ACSR_DIV_W         = 6;

  localparam logic [2:0] ACSR_CS_RESET      = 3'h0;
  localparam logic [1:0] ACSR_CS_RC_TAIL    = 2'h3;
  localparam logic       ACSR_FMT_RESET     = 1'b0;
  localparam logic [7:0] ACSR_RES_RESET     = 8'h00;
  localparam logic       ACSR_HRESP_OKAY    = 1'b0;

  typedef logic [2:0] acsr_clk_code_type;

  typedef struct packed {
    logic                  done;
    logic [ACSR_RES_W-1:0] data;
  } acsr_result_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } acsr_dphase_type;

  // Counter bit whose toggle rate gives the selected divide ratio
  function automatic int acsr_div_bit(input acsr_clk_code_type code);
    case (code)
      3'h0:    acsr_div_bit = 0;
      3'h4:    acsr_div_bit = 1;
      3'h1:    acsr_div_bit = 2;
      3'h5:    acsr_div_bit = 3;
      3'h2:    acsr_div_bit = 4;
      3'h6:    acsr_div_bit = 5;
      default: acsr_div_bit = 0;
    endcase
  endfunction : acsr_div_bit

endpackage : acsr_pkg

/* src/acsr_top.sv */
// AHB-Lite register slave for converter clock select and result bytes
`timescale 1ns/1ns
module acsr_top (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  input  acsr_pkg::acsr_result_type     result,
  input  wire logic                     rc_clk_pin,
  output logic                          conv_clk,
  output logic                          rc_mode,
  output logic                          result_justify_format
);
  import acsr_pkg::*;

  acsr_dphase_type   dph_q;
  acsr_dphase_type   dph_d;
  acsr_clk_code_type conv_clock_select_q;
  acsr_clk_code_type conv_clock_select_d;
  logic              fmt_q;
  logic              fmt_d;
  logic [7:0]        result_high_byte_q;
  logic [7:0]        result_high_byte_d;
  logic [7:0]        result_low_byte_q;
  logic [7:0]        result_low_byte_d;
  logic [31:0]       hrdata_q;
  logic [31:0]       hrdata_d;
  logic [31:0]       rd_word;
  logic              hreadyout_q;
  logic              hresp_q;
  logic              addr_take;

  // Word-only bus; hsize is accepted but not decoded
  logic              unused_size;
  assign unused_size = ^hsize;

  always_comb begin
    addr_take = hsel && hready && htrans[1];
    dph_d.valid = addr_take;
    dph_d.write = hwrite;
    dph_d.addr  = haddr[7:0];

    conv_clock_select_d = conv_clock_select_q;
    fmt_d = fmt_q;
    if (dph_q.valid && dph_q.write) begin
      case (dph_q.addr)
        // Only bits 6..4 are stored, other lanes dropped
        ACSR_OFS_CCC: conv_clock_select_d = hwdata[ACSR_CS_MSB:ACSR_CS_LSB];
        ACSR_OFS_FMT: fmt_d = hwdata[ACSR_FMT_BIT];
        // Result bytes are read-only, writes fall through
        default: ;
      endcase
    end

    result_high_byte_d = result_high_byte_q;
    result_low_byte_d  = result_low_byte_q;
    // Format sampled at conversion end, not at read time
    if (result.done) begin
      if (fmt_q) begin
        result_high_byte_d = {6'h00, result.data[9:8]};
        result_low_byte_d  = result.data[7:0];
      end else begin
        result_high_byte_d = result.data[9:2];
        result_low_byte_d  = {result.data[1:0], 6'h00};
      end
    end

    // Next values are muxed so a read right after a write sees the new value
    case (haddr[7:0])
      ACSR_OFS_CCC: rd_word = 32'(conv_clock_select_d) << ACSR_CS_LSB;
      ACSR_OFS_RHI: rd_word = {24'h000000, result_high_byte_d};
      ACSR_OFS_RLO: rd_word = {24'h000000, result_low_byte_d};
      ACSR_OFS_FMT: rd_word = 32'(fmt_d) << ACSR_FMT_BIT;
      default:      rd_word = 32'h00000000;
    endcase
    hrdata_d = (addr_take && !hwrite) ? rd_word : 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q               <= '0;
      conv_clock_select_q <= ACSR_CS_RESET;
      fmt_q               <= ACSR_FMT_RESET;
      result_high_byte_q  <= ACSR_RES_RESET;
      result_low_byte_q   <= ACSR_RES_RESET;
      hrdata_q            <= 32'h00000000;
      hreadyout_q         <= 1'b1;
      hresp_q             <= ACSR_HRESP_OKAY;
    end else begin
      dph_q               <= dph_d;
      conv_clock_select_q <= conv_clock_select_d;
      fmt_q               <= fmt_d;
      result_high_byte_q  <= result_high_byte_d;
      result_low_byte_q   <= result_low_byte_d;
      hrdata_q            <= hrdata_d;
      hreadyout_q         <= 1'b1;
      hresp_q             <= ACSR_HRESP_OKAY;
    end
  end

  assign hreadyout             = hreadyout_q;
  assign hrdata                = hrdata_q;
  assign hresp                 = hresp_q;
  assign result_justify_format = fmt_q;

  acsr_clk_sel u_clk_sel (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clk_code   (conv_clock_select_q),
    .rc_clk_pin (rc_clk_pin),
    .conv_clk   (conv_clk),
    .rc_mode    (rc_mode)
  );

  sequence seq_ccc_wr;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == ACSR_OFS_CCC;
  endsequence

  sequence seq_ccc_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ACSR_OFS_CCC;
  endsequence

  chk_ccc_write: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_ccc_wr ##1 1'b1 |=> conv_clock_select_q == $past(hwdata[6:4]))
    else $error("clock select field did not take written value");

  chk_ccc_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_ccc_wr ##1 seq_ccc_rd |=> hrdata[6:4] == $past(hwdata[6:4]))
    else $error("back to back read missed written clock select");

  chk_ccc_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (dph_q.valid && !dph_q.write && dph_q.addr == ACSR_OFS_CCC)
      |-> (hrdata[7] == 1'b0 && hrdata[3:0] == 4'h0 && hrdata[31:8] == 24'h000000))
    else $error("unimplemented control bits not zero");

  chk_left_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (result.done && !fmt_q) |=> result_high_byte_q == $past(result.data[9:2]))
    else $error("left high byte wrong");

  chk_left_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (result.done && !fmt_q) |=> result_low_byte_q == {$past(result.data[1:0]), 6'h00})
    else $error("left low byte wrong");

  chk_right_just: assert property (@(posedge hclk) disable iff (!hresetn)
    (result.done && fmt_q) |=> (result_high_byte_q == {6'h00, $past(result.data[9:8])}
      && result_low_byte_q == $past(result.data[7:0])))
    else $error("right justified bytes wrong");

  chk_ccc_reset: assert property (@(posedge hclk)
    !hresetn |-> conv_clock_select_q == 3'h0)
    else $error("clock select not zero in reset");

  chk_res_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !result.done |=> ($stable(result_high_byte_q) && $stable(result_low_byte_q)))
    else $error("result bytes changed without conversion end");

  // Bus handshake is fixed: no wait states, no error response
  chk_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout)
    else $error("hreadyout dropped");

  chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == ACSR_HRESP_OKAY)
    else $error("hresp not OKAY");

  // Read data parked at zero so a stale byte never leaks onto the bus
  chk_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !(dph_q.valid && !dph_q.write) |-> hrdata == 32'h00000000)
    else $error("read data not zero outside a read data phase");

  sequence seq_fmt_wr;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == ACSR_OFS_FMT;
  endsequence

  sequence seq_fmt_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ACSR_OFS_FMT;
  endsequence

  sequence seq_rhi_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ACSR_OFS_RHI;
  endsequence

  sequence seq_rlo_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ACSR_OFS_RLO;
  endsequence

  // Any byte address outside the four registers
  sequence seq_unmapped_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] != ACSR_OFS_CCC && haddr[7:0] != ACSR_OFS_RHI
      && haddr[7:0] != ACSR_OFS_RLO && haddr[7:0] != ACSR_OFS_FMT;
  endsequence

  chk_fmt_write: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_fmt_wr ##1 1'b1 |=> fmt_q == $past(hwdata[ACSR_FMT_BIT]))
    else $error("format bit did not take written value");

  chk_fmt_read: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_fmt_rd |=> hrdata == {31'h00000000, fmt_q})
    else $error("format bit read back wrong");

  chk_ccc_read: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_ccc_rd |=> hrdata == {25'h0000000, conv_clock_select_q, 4'h0})
    else $error("clock select read back wrong");

  // Select only moves on a write data phase to its own address
  chk_ccc_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(dph_q.valid && dph_q.write && dph_q.addr == ACSR_OFS_CCC) |=> $stable(conv_clock_select_q))
    else $error("clock select changed without a write");

  chk_high_read: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_rhi_rd |=> hrdata == {24'h000000, result_high_byte_q})
    else $error("high result byte read back wrong");

  chk_low_read: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_rlo_rd |=> hrdata == {24'h000000, result_low_byte_q})
    else $error("low result byte read back wrong");

  chk_unmapped_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_unmapped_rd |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

endmodule : acsr_top

/* testbench/tb.sv */
// Self-checking bench for the converter clock select and result register slave
`timescale 1ns/1ns
module tb;
  import acsr_pkg::*;
  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic                 hreadyout;
  logic [31:0]          hrdata;
  logic                 hresp;
  acsr_result_type      result;
  logic                 rc_clk_pin;
  logic                 conv_clk;
  logic                 rc_mode;
  logic                 fmt;
  logic [31:0]          rd;
  int                   n_mismatch;
  int                   n_checks;
  int                   cyc;
  int                   edges;
  logic                 prev_clk;
  // Row: select code, expected rc_mode, conv_clk falling edges in 128 cycles
  logic [10:0]          rows [8] = '{{3'h0, 1'b0, 7'h40}, {3'h4, 1'b0, 7'h20}, {3'h1, 1'b0, 7'h10},
                                     {3'h5, 1'b0, 7'h08}, {3'h2, 1'b0, 7'h04}, {3'h6, 1'b0, 7'h02},
                                     {3'h3, 1'b1, 7'h08}, {3'h7, 1'b1, 7'h08}};

  acsr_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .result(result), .rc_clk_pin(rc_clk_pin), .conv_clk(conv_clk),
    .rc_mode(rc_mode), .result_justify_format(fmt));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // RC pin period of 16 hclk cycles, edges kept away from hclk rising edges
  initial begin
    rc_clk_pin = 1'b0;
    forever #400 rc_clk_pin = ~rc_clk_pin;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("MISMATCH run_length expected below %0d seen %0d", 20000, cyc);
      end_sim();
    end
  end

  // One transfer; address phase held until hready, data phase likewise
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  // Write followed at once by a read of the same address, pipelined
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : wr_rd

  task automatic conv(input logic f, input logic [9:0] d);
    xfer(1'b1, ACSR_OFS_FMT, {31'h0, f}, rd);
    result.done <= 1'b1;
    result.data <= d;
    @(posedge hclk);
    chk("result_justify_format", {31'h0, f}, {31'h0, fmt});
    result.done <= 1'b0;
    xfer(1'b0, ACSR_OFS_RHI, 32'h0, rd);
    chk("result_high_byte", f ? {30'h0, d[9:8]} : {24'h0, d[9:2]}, rd);
    xfer(1'b0, ACSR_OFS_RLO, 32'h0, rd);
    if (f) chk("result_low_byte", {24'h0, d[7:0]}, rd);
    else chk("result_low_byte", {24'h0, d[1:0], 6'h0}, rd & 32'hffffffc0);
  endtask : conv

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    hresetn = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    result = '0;
    // Asserted just after time zero so the asynchronous reset edge is seen
    #1 hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    chk("hreadyout in reset", 32'h1, {31'h0, hreadyout});
    chk("hrdata in reset", 32'h0, hrdata);
    chk("conv_clk in reset", 32'h0, {31'h0, conv_clk});
    chk("rc_mode in reset", 32'h0, {31'h0, rc_mode});
    chk("format in reset", 32'h0, {31'h0, fmt});
    hresetn <= 1'b1;
    xfer(1'b0, ACSR_OFS_CCC, 32'h0, rd);
    chk("ccc after reset", 32'h0, rd);
    foreach (rows[i]) begin
      // Unused bits written as ones must read back zero
      xfer(1'b1, ACSR_OFS_CCC, {24'hffffff, 1'b1, rows[i][10:8], 4'hf}, rd);
      xfer(1'b0, ACSR_OFS_CCC, 32'h0, rd);
      chk("ccc readback", {25'h0, rows[i][10:8], 4'h0}, rd);
      repeat (16) @(posedge hclk);
      chk("rc_mode", {31'h0, rows[i][7]}, {31'h0, rc_mode});
      edges = 0;
      prev_clk = conv_clk;
      repeat (128) begin
        @(negedge hclk);
        if (prev_clk === 1'b1 && conv_clk === 1'b0) edges++;
        prev_clk = conv_clk;
      end
      chk("conv_clk falling count", {25'h0, rows[i][6:0]}, edges);
    end
    conv(1'b0, 10'h3ff);
    conv(1'b0, 10'h2a5);
    conv(1'b1, 10'h35a);
    conv(1'b1, 10'h0ff);
    xfer(1'b0, ACSR_OFS_FMT, 32'h0, rd);
    chk("format readback", 32'h1, rd);
    // Format change later must not re-justify the held result
    xfer(1'b1, ACSR_OFS_FMT, 32'h0, rd);
    xfer(1'b0, ACSR_OFS_RLO, 32'h0, rd);
    chk("low byte after format change", 32'hff, rd);
    // Result bytes are read-only
    xfer(1'b1, ACSR_OFS_RLO, 32'h12, rd);
    xfer(1'b0, ACSR_OFS_RLO, 32'h0, rd);
    chk("low byte after write", 32'hff, rd);
    xfer(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    wr_rd(ACSR_OFS_CCC, 32'hd5, rd);
    chk("ccc back to back", 32'h50, rd);
    // Second reset in mid-run clears the select field
    xfer(1'b1, ACSR_OFS_CCC, 32'h60, rd);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, ACSR_OFS_CCC, 32'h0, rd);
    chk("ccc after second reset", 32'h0, rd);
    end_sim();
  end
endmodule : tb
